// *** include/pfr_defines.svh ***
// register offsets, field positions and reset values of the port F and pin relocation block
// assumes a 32-bit AXI4-Lite slave with one aligned word per register
`ifndef PFR_DEFINES_SVH
`define PFR_DEFINES_SVH

`define PFR_ADDR_W         8
`define PFR_OFF_OUT_LATCH  8'h00
`define PFR_OFF_PIN_DIR    8'h04
`define PFR_OFF_IRQ_UPPER  8'h08
`define PFR_OFF_IRQ_LOWER  8'h0C
`define PFR_OFF_ROUTE_CTL  8'h10
`define PFR_PF_W           3
`define PFR_RST_3          3'h0
`define PFR_RST_8          8'h00
`define PFR_ROUTE_TMI0     7
`define PFR_ROUTE_TMI1     6
`define PFR_ROUTE_TMIX     5
`define PFR_ROUTE_TMIY     4
`define PFR_ROUTE_PWM_RELOCATION_SELECT     2
`define PFR_RESP_OKAY      2'h0
`define PFR_RESP_DECERR    2'h3

`endif

// *** include/pfr_pkg.sv ***
// types shared by the port F and pin relocation block
// assumes pfr_defines.svh gives the widths
`include "pfr_defines.svh"
package pfr_pkg;
  // port F pin drive as two wires per pin, out and active-low oe_n
  typedef struct packed {
    logic [`PFR_PF_W-1:0] out;
    logic [`PFR_PF_W-1:0] oe_n;
  } pfr_pin_drive_t;

  // pwm channels from the timer
  typedef struct packed {
    logic [`PFR_PF_W-1:0] wave;
    logic [`PFR_PF_W-1:0] enable;
  } pfr_pwm_t;

  // routed timer clock inputs
  typedef struct packed {
    logic tmi0;
    logic tmi1;
    logic tmix;
    logic tmiy;
  } pfr_tmi_t;
endpackage : pfr_pkg

// *** rtl/pfr_sync.sv ***
// two-flop synchroniser, one per bit
// assumes d comes from outside the aclk domain
`timescale 1ns/10ps
module pfr_sync #(
  parameter int W = 1
) (
  // clock, reset, enable
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         ce,
  // data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  // first stage feeds only the second stage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_r <= '0;
      q      <= '0;
    end else if (ce) begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule : pfr_sync

// *** rtl/pfr_port_f.sv ***
// port F general port, pwm pin sharing and peripheral pin relocation
// assumes an AXI4-Lite master, pins resolved outside from out/oe_n
//
// Our own choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/10ps
`include "pfr_defines.svh"
module pfr_port_f (
  // clock, reset, enable
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic                  ce,
  // axi4-lite write address and data
  input  wire logic [`PFR_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  // axi4-lite read
  input  wire logic [`PFR_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // port F pins
  input  wire logic [2:0]            port_f_in,
  output pfr_pkg::pfr_pin_drive_t    port_f_drive,
  // pwm timer side
  input  pfr_pkg::pfr_pwm_t          pwm_in,
  output logic [2:0]                 port1_pwm_out,
  output logic [2:0]                 port1_pwm_en,
  // pins for relocation
  input  wire logic [7:0]            port4_in,
  input  wire logic [7:0]            port5_in,
  input  wire logic [7:0]            port7_in,
  input  wire logic [7:0]            port8_in,
  // routed peripheral inputs
  output logic [15:0]                relocated_interrupt_in,
  output pfr_pkg::pfr_tmi_t          timer_clock_in
);
  logic [2:0]  port_f_output_latch_r;
  logic [2:0]  port_f_direction_r;
  logic [15:8] irq_route_upper_r;
  logic [7:0]  irq_route_lower_r;
  logic [7:0]  timer_pwm_route_control_r;
  logic [2:0]  pf_sync;
  logic [7:0]  p4_s, p5_s, p7_s, p8_s;
  logic        aw_held_r, w_held_r;
  logic [`PFR_ADDR_W-1:0] aw_addr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic        wr_go;
  logic        pwm_sel;

  // pins come from outside, so every pin read passes two flops
  pfr_sync #(.W(35)) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .d       ({port_f_in, port4_in, port5_in, port7_in, port8_in}),
    .q       ({pf_sync, p4_s, p5_s, p7_s, p8_s})
  );

  // address and data channels taken separately, in either order
  assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_r && !s_axi_bvalid;
  assign wr_go         = aw_held_r && w_held_r && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      aw_addr_r <= '0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_held_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_r <= 1'b0;
      wdata_r  <= '0;
      wstrb_r  <= '0;
    end else if (ce) begin
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end else if (wr_go) begin
        w_held_r <= 1'b0;
      end
    end
  end

  // write response, decode error for unmapped words
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `PFR_RESP_OKAY;
    end else if (ce) begin
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        unique case (aw_addr_r)
          `PFR_OFF_OUT_LATCH, `PFR_OFF_PIN_DIR, `PFR_OFF_IRQ_UPPER,
          `PFR_OFF_IRQ_LOWER, `PFR_OFF_ROUTE_CTL: s_axi_bresp <= `PFR_RESP_OKAY;
          default:                                s_axi_bresp <= `PFR_RESP_DECERR;
        endcase
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // register stores; only bits 2..0 of latch and direction exist
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_f_output_latch_r <= `PFR_RST_3;
    end else if (ce && wr_go && aw_addr_r == `PFR_OFF_OUT_LATCH && wstrb_r[0]) begin
      port_f_output_latch_r <= wdata_r[2:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_f_direction_r <= `PFR_RST_3;
    end else if (ce && wr_go && aw_addr_r == `PFR_OFF_PIN_DIR && wstrb_r[0]) begin
      port_f_direction_r <= wdata_r[2:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_route_upper_r <= `PFR_RST_8;
    end else if (ce && wr_go && aw_addr_r == `PFR_OFF_IRQ_UPPER && wstrb_r[1]) begin
      irq_route_upper_r <= wdata_r[15:8];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_route_lower_r <= `PFR_RST_8;
    end else if (ce && wr_go && aw_addr_r == `PFR_OFF_IRQ_LOWER && wstrb_r[0]) begin
      irq_route_lower_r <= wdata_r[7:0];
    end
  end

  // reserved bits 3, 1, 0 are stored as written
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_pwm_route_control_r <= `PFR_RST_8;
    end else if (ce && wr_go && aw_addr_r == `PFR_OFF_ROUTE_CTL && wstrb_r[0]) begin
      timer_pwm_route_control_r <= wdata_r[7:0];
    end
  end

  // read channel; one read at a time, answer one cycle after arvalid
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= `PFR_RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `PFR_RESP_OKAY;
        unique case (s_axi_araddr)
          // undefined upper bits are given as zero
          `PFR_OFF_OUT_LATCH: s_axi_rdata <= {29'h0, port_f_output_latch_r};
          `PFR_OFF_PIN_DIR:   s_axi_rdata <= {29'h0, pf_sync};
          `PFR_OFF_IRQ_UPPER: s_axi_rdata <= {16'h0, irq_route_upper_r, 8'h00};
          `PFR_OFF_IRQ_LOWER: s_axi_rdata <= {24'h0, irq_route_lower_r};
          `PFR_OFF_ROUTE_CTL: s_axi_rdata <= {24'h0, timer_pwm_route_control_r};
          default: begin
            s_axi_rdata <= '0;
            s_axi_rresp <= `PFR_RESP_DECERR;
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // pin drive: pwm when selected and enabled, else general port
  assign pwm_sel = timer_pwm_route_control_r[`PFR_ROUTE_PWM_RELOCATION_SELECT];

  genvar n;
  generate
    for (n = 0; n < `PFR_PF_W; n++) begin : g_pin
      logic pwm_pin;
      assign pwm_pin = pwm_sel && pwm_in.enable[n];
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          port_f_drive.out[n]  <= 1'b0;
          port_f_drive.oe_n[n] <= 1'b1;
          port1_pwm_out[n]     <= 1'b0;
          port1_pwm_en[n]      <= 1'b0;
        end else if (ce) begin
          port_f_drive.out[n]  <= pwm_pin ? pwm_in.wave[n] : port_f_output_latch_r[n];
          port_f_drive.oe_n[n] <= !(pwm_pin || port_f_direction_r[n]);
          port1_pwm_out[n]     <= pwm_in.wave[n];
          port1_pwm_en[n]      <= !pwm_sel && pwm_in.enable[n];
        end
      end
    end
  endgenerate

  // relocated peripheral inputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      relocated_interrupt_in <= '0;
      timer_clock_in         <= '0;
    end else if (ce) begin
      for (int i = 8; i < 16; i++) begin
        relocated_interrupt_in[i] <= irq_route_upper_r[i] ? p8_s[i-8] : p5_s[i-8];
      end
      for (int i = 2; i < 8; i++) begin
        relocated_interrupt_in[i] <= irq_route_lower_r[i] ? p7_s[i] : p4_s[i];
      end
      relocated_interrupt_in[1:0] <= p4_s[1:0];
      timer_clock_in.tmi0 <= timer_pwm_route_control_r[`PFR_ROUTE_TMI0] ? p8_s[4] : p4_s[0];
      timer_clock_in.tmi1 <= timer_pwm_route_control_r[`PFR_ROUTE_TMI1] ? p8_s[5] : p4_s[1];
      timer_clock_in.tmix <= timer_pwm_route_control_r[`PFR_ROUTE_TMIX] ? p8_s[6] : p4_s[4];
      timer_clock_in.tmiy <= timer_pwm_route_control_r[`PFR_ROUTE_TMIY] ? p8_s[7] : p4_s[5];
    end
  end
endmodule : pfr_port_f

// *** testbench/pfr_pins_model.sv ***
// far side of port F: resolves each pin wire from the block and the board
// assumes the board drives weakly and always loses to the block
`timescale 1ns/10ps
module pfr_pins_model (
  // block side
  input  pfr_pkg::pfr_pin_drive_t drive,
  // board side
  input  wire logic [2:0]         ext_lvl,
  output logic      [2:0]         pin_lvl
);
  assign pin_lvl = (~drive.oe_n & drive.out) | (drive.oe_n & ext_lvl);
endmodule : pfr_pins_model

// *** testbench/pfr_port_f_assertions.sv ***
// port-level checks of the port F and pin relocation block
// assumes ce is held high by the bench
`timescale 1ns/10ps
module pfr_port_f_assertions (
  // clock and reset
  input wire logic                    aclk,
  input wire logic                    aresetn,
  // bus
  input wire logic                    s_axi_awvalid,
  input wire logic                    s_axi_awready,
  input wire logic                    s_axi_wvalid,
  input wire logic                    s_axi_wready,
  input wire logic                    s_axi_bvalid,
  input wire logic                    s_axi_bready,
  input wire logic                    s_axi_arvalid,
  input wire logic                    s_axi_arready,
  input wire logic [31:0]             s_axi_rdata,
  input wire logic                    s_axi_rvalid,
  input wire logic                    s_axi_rready,
  // pins and peripherals
  input wire pfr_pkg::pfr_pin_drive_t port_f_drive,
  input wire pfr_pkg::pfr_pwm_t       pwm_in,
  input wire logic [2:0]              port1_pwm_en,
  input wire logic [7:0]              port4_in,
  input wire logic [7:0]              port5_in,
  input wire logic [7:0]              port7_in,
  input wire logic [7:0]              port8_in,
  input wire logic [15:0]             relocated_interrupt_in
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // routed inputs are only comparable once the synchronisers hold real pin values
  logic [1:0] up_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) up_r <= 2'h0;
    else if (up_r != 2'h3) up_r <= up_r + 2'h1;
  end
  rst_release_a: assert property (disable iff (1'b0) !aresetn |=>
    port_f_drive.oe_n == 3'h7 && !s_axi_bvalid && !s_axi_rvalid) else $error("reset state");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer moved");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("late read answer");
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |=> ##1 s_axi_bvalid) else $error("late write answer");
  wr_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answering");
  pwm_gate_a: assert property ((port1_pwm_en & ~$past(pwm_in.enable)) == 3'h0)
    else $error("port 1 pwm without enable");
  irq_fixed_a: assert property (up_r == 2'h3 |->
    relocated_interrupt_in[1:0] == $past(port4_in[1:0], 3)) else $error("irq 1..0 route");
  irq_lower_a: assert property (up_r == 2'h3 |->
    ((relocated_interrupt_in[7:2] ^ $past(port4_in[7:2], 3)) &
     (relocated_interrupt_in[7:2] ^ $past(port7_in[7:2], 3))) == 6'h00) else $error("irq lo");
  irq_upper_a: assert property (up_r == 2'h3 |->
    ((relocated_interrupt_in[15:8] ^ $past(port5_in, 3)) &
     (relocated_interrupt_in[15:8] ^ $past(port8_in, 3))) == 8'h00) else $error("irq hi");
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (s_axi_rvalid && s_axi_rready);
  cover property (port_f_drive.oe_n == 3'h0);
endmodule : pfr_port_f_assertions
bind pfr_port_f pfr_port_f_assertions pfr_port_f_assertions_i (.*);

// *** testbench/testbench.sv ***
// self-checking bench for the port F and pin relocation block
// assumes ce, strobes and response readies may stay high throughout
`timescale 1ns/10ps
module testbench;
  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [7:0] p4 = 8'hA5, p5 = 8'h3C, p7 = 8'h5A, p8 = 8'hC3;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [1:0] bresp, rresp, r, rb;
  logic [2:0] pin_lvl, ext_lvl = 3'h6, p1_out, p1_en;
  logic [15:0] irq;
  pfr_pkg::pfr_pin_drive_t drv;
  pfr_pkg::pfr_pwm_t pwm = '0;
  pfr_pkg::pfr_tmi_t tmi;
  int fail_count = 0, samples_checked = 0, cycles = 0;
  always #12.5 aclk = ~aclk;
  pfr_port_f pfr_port_f_i (.aclk(aclk), .aresetn(aresetn), .ce(1'b1),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
    .port_f_in(pin_lvl), .port_f_drive(drv), .pwm_in(pwm), .port1_pwm_out(p1_out),
    .port1_pwm_en(p1_en), .port4_in(p4), .port5_in(p5), .port7_in(p7), .port8_in(p8),
    .relocated_interrupt_in(irq), .timer_clock_in(tmi));
  pfr_pins_model pfr_pins_model_i (.drive(drv), .ext_lvl(ext_lvl), .pin_lvl(pin_lvl));
  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_sim
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fail_count++;
      end_sim;
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  // readies are sampled half a cycle early: they only move at rising edges
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    @(negedge aclk);
    while (!(awready && wready)) @(negedge aclk);
    @(posedge aclk);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    @(negedge aclk);
    while (!bvalid) @(negedge aclk);
    rb = bresp;
    @(posedge aclk);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    @(negedge aclk);
    while (!arready) @(negedge aclk);
    @(posedge aclk);
    arvalid <= 1'b0;
    @(negedge aclk);
    while (!rvalid) @(negedge aclk);
    d = rdata;
    r = rresp;
    @(posedge aclk);
  endtask : rd
  task automatic t_reset;
    rd(8'h00);
    check(d, 32'h0);
    rd(8'h08);
    check(d, 32'h0);
    rd(8'h0C);
    check(d, 32'h0);
    rd(8'h10);
    check(d, 32'h0);
    check(32'(drv.oe_n), 32'h7);
    rd(8'h04);
    check(d, 32'h6);
    ext_lvl <= 3'h0;
  endtask : t_reset
  task automatic t_port;
    wr(8'h00, 32'hFFFFFFFF);
    rd(8'h00);
    check(d, 32'h7);
    wr(8'h04, 32'h5);
    repeat (4) @(posedge aclk);
    check(32'(drv.oe_n), 32'h2);
    rd(8'h04);
    check(d, 32'h5);
    ext_lvl <= 3'h2;
    wr(8'h00, 32'h2);
    repeat (4) @(posedge aclk);
    rd(8'h04);
    check(d, 32'h2);
    rd(8'h00);
    check(d, 32'h2);
  endtask : t_port
  task automatic t_pwm;
    pwm <= '{wave: 3'h5, enable: 3'h3};
    repeat (2) @(posedge aclk);
    check(32'(p1_en), 32'h3);
    check(32'(p1_out), 32'h5);
    wr(8'h10, 32'h4);
    repeat (2) @(posedge aclk);
    check(32'(p1_en), 32'h0);
    check(32'(drv), 32'h08);
    pwm <= '{wave: 3'h5, enable: 3'h1};
    repeat (2) @(posedge aclk);
    check(32'(drv), 32'h1A);
  endtask : t_pwm
  task automatic t_route;
    wr(8'h0C, 32'hFF);
    wr(8'h08, 32'hFF00);
    repeat (4) @(posedge aclk);
    check(32'(irq), {16'h0, p8, p7[7:2], p4[1:0]});
    check(32'(tmi), {28'h0, p4[0], p4[1], p4[4], p4[5]});
    wr(8'h10, 32'hF0);
    wr(8'h08, 32'h0);
    wr(8'h0C, 32'h3);
    repeat (4) @(posedge aclk);
    check(32'(irq), {16'h0, p5, p4});
    check(32'(tmi), {28'h0, p8[4], p8[5], p8[6], p8[7]});
    rd(8'h0C);
    check(d, 32'h3);
    wr(8'h10, 32'h0B);
    rd(8'h10);
    check(d, 32'h0B);
    rd(8'h14);
    check(32'(r), 32'h3);
    wr(8'h14, 32'h1);
    check(32'(rb), 32'h3);
  endtask : t_route
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    t_port;
    t_pwm;
    t_route;
    end_sim;
  end
endmodule : testbench
